// ===== ambwp_host.sv
// host controller for an asynchronous 128K x 16 memory with a software
// sector write-protect unlock sequence; APB slave for software orders
// assumes APB master on pclk and a memory whose inputs settle within pclk
`timescale 1ns/1ps
`include "ambwp_regs.svh"

module ambwp_host
  import ambwp_pkg::*;
#(
  parameter int SETUP_CYC  = `AMBWP_SETUP_CYC,
  parameter int ACCESS_CYC = `AMBWP_ACCESS_CYC,
  parameter int PRECH_CYC  = `AMBWP_PRECH_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_ce_n,
  output logic             mem_we_n,
  output logic             mem_oe_n,
  output logic             upper_byte_select_n,
  output logic             lower_byte_select_n,
  output logic      [16:0] mem_addr,
  output logic      [15:0] mem_dq_o,
  output logic             mem_dq_oe,
  input  wire logic [15:0] mem_dq_i
);
  ambwp_mem_if mem ();

  ambwp_seq_state_type seq_q;
  logic [3:0]  step_q;
  logic        op_write_q, op_prot_q;
  logic [16:0] addr_q;
  logic [15:0] wdata_q, rdata_q;
  logic [1:0]  be_q;
  logic [7:0]  prot_q, prot_shadow_q;
  logic        done_q, refused_q;
  logic        req_q, mwrite_q;
  logic [16:0] maddr_q;
  logic [15:0] mwdata_q;
  logic [1:0]  mbe_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;

  logic        busy, acc_wr, acc_rd, hit, start, last;
  logic        st_write;
  logic [16:0] st_addr;
  logic [15:0] st_data;
  logic [1:0]  st_be;
  logic [31:0] rd_mux;

  assign busy   = (seq_q != SQ_IDLE);
  // one-wait-state slave: pready rises in the second access cycle
  assign acc_wr = psel && penable && pready_q && pwrite;
  assign acc_rd = psel && penable && !pready_q;
  assign hit    = (paddr == `AMBWP_CTRL_OFS) || (paddr == `AMBWP_ADDR_OFS)
               || (paddr == `AMBWP_WDATA_OFS) || (paddr == `AMBWP_PROT_OFS)
               || (paddr == `AMBWP_STAT_OFS) || (paddr == `AMBWP_RDATA_OFS);
  assign start  = acc_wr && !busy && (paddr == `AMBWP_CTRL_OFS)
               && pwdata[`AMBWP_CTRL_START];
  assign last   = !op_prot_q || (step_q == `AMBWP_STEP_LAST);

  // APB handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= acc_rd;
      pslverr_q <= acc_rd && !hit;
      if (acc_rd) prdata_q <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      `AMBWP_CTRL_OFS: begin
        rd_mux[`AMBWP_CTRL_WRITE] = op_write_q;
        rd_mux[`AMBWP_CTRL_PROT]  = op_prot_q;
      end
      `AMBWP_ADDR_OFS:  rd_mux[16:0] = addr_q;
      `AMBWP_WDATA_OFS: rd_mux[17:0] = {be_q, wdata_q};
      `AMBWP_PROT_OFS:  rd_mux[7:0]  = prot_q;
      `AMBWP_STAT_OFS: begin
        rd_mux[`AMBWP_STAT_BUSY]  = busy;
        rd_mux[`AMBWP_STAT_DONE]  = done_q;
        rd_mux[`AMBWP_STAT_REFUS] = refused_q;
        rd_mux[15:8]              = prot_shadow_q;
      end
      `AMBWP_RDATA_OFS: rd_mux[15:0] = rdata_q;
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // order registers; frozen while a sequence runs so the complement
  // always matches the byte already sent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_write_q <= 1'b0;
      op_prot_q  <= 1'b0;
      addr_q     <= 17'h00000;
      wdata_q    <= 16'h0000;
      be_q       <= `AMBWP_BE_RST;
      prot_q     <= 8'h00;
    end else if (acc_wr && !busy) begin
      case (paddr)
        `AMBWP_CTRL_OFS: begin
          op_write_q <= pwdata[`AMBWP_CTRL_WRITE];
          op_prot_q  <= pwdata[`AMBWP_CTRL_PROT];
        end
        `AMBWP_ADDR_OFS:  addr_q <= pwdata[16:0];
        `AMBWP_WDATA_OFS: begin
          wdata_q <= pwdata[15:0];
          be_q    <= pwdata[17:16];
        end
        `AMBWP_PROT_OFS:  prot_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // sticky flags: a hardware set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q    <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (seq_q == SQ_WAIT && mem.ack && last) done_q <= 1'b1;
      else if (acc_wr && paddr == `AMBWP_STAT_OFS
               && pwdata[`AMBWP_STAT_DONE]) done_q <= 1'b0;
      if (acc_wr && busy && paddr != `AMBWP_STAT_OFS) refused_q <= 1'b1;
      else if (acc_wr && paddr == `AMBWP_STAT_OFS
               && pwdata[`AMBWP_STAT_REFUS]) refused_q <= 1'b0;
    end
  end

  // one step of the current order; protect orders walk the fixed table
  always_comb begin
    st_write = op_write_q;
    st_addr  = addr_q;
    st_data  = wdata_q;
    st_be    = be_q;
    if (op_prot_q) begin
      st_write = 1'b0;
      st_data  = 16'h0000;
      st_be    = 2'h3;
      case (step_q)
        4'h0: st_addr = `AMBWP_SEQ_A0;
        4'h1: st_addr = `AMBWP_SEQ_A1;
        4'h2: st_addr = `AMBWP_SEQ_A2;
        4'h3: st_addr = `AMBWP_SEQ_A3;
        4'h4: st_addr = `AMBWP_SEQ_A4;
        4'h5: st_addr = `AMBWP_SEQ_A5;
        4'h6: begin
          st_write = 1'b1;
          st_addr  = `AMBWP_SEQ_A1;
          st_data  = {8'h00, prot_q};
        end
        4'h7: begin
          st_write = 1'b1;
          st_addr  = `AMBWP_SEQ_A3;
          st_data  = {8'h00, ~prot_q};
        end
        4'h8: begin
          st_write = 1'b1;
          st_addr  = `AMBWP_SEQ_A8;
        end
        4'h9: st_addr = `AMBWP_SEQ_A9;
        default: st_addr = `AMBWP_SEQ_A9;
      endcase
    end
  end

  // sequencer: one engine, so nothing can interleave with an unlock walk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q  <= SQ_IDLE;
      step_q <= 4'h0;
    end else begin
      case (seq_q)
        SQ_IDLE: if (start) begin
          seq_q  <= SQ_ISSUE;
          step_q <= 4'h0;
        end
        SQ_ISSUE: seq_q <= SQ_WAIT;
        SQ_WAIT: if (mem.ack) begin
          if (last) seq_q <= SQ_IDLE;
          else begin
            seq_q  <= SQ_ISSUE;
            step_q <= step_q + 4'h1;
          end
        end
        default: seq_q <= SQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q    <= 1'b0;
      mwrite_q <= 1'b0;
      maddr_q  <= 17'h00000;
      mwdata_q <= 16'h0000;
      mbe_q    <= 2'h0;
    end else begin
      req_q <= (seq_q == SQ_ISSUE);
      if (seq_q == SQ_ISSUE) begin
        mwrite_q <= st_write;
        maddr_q  <= st_addr;
        mwdata_q <= st_data;
        mbe_q    <= st_be;
      end
    end
  end

  // read data and the believed protection state; factory state is clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q       <= 16'h0000;
      prot_shadow_q <= 8'h00;
    end else if (seq_q == SQ_WAIT && mem.ack) begin
      if (!mwrite_q) rdata_q <= mem.rdata;
      if (op_prot_q && last) prot_shadow_q <= prot_q;
    end
  end

  assign mem.req   = req_q;
  assign mem.write = mwrite_q;
  assign mem.addr  = maddr_q;
  assign mem.wdata = mwdata_q;
  assign mem.be    = mbe_q;

  // every access frames itself with chip select, so address changes never
  // rely on the memory's own change detection; no page mode is used
  ambwp_cycle #(
    .SETUP_CYC  (SETUP_CYC),
    .ACCESS_CYC (ACCESS_CYC),
    .PRECH_CYC  (PRECH_CYC)
  ) ambwp_cycle_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .mem     (mem),
    .ce_n    (mem_ce_n),
    .we_n    (mem_we_n),
    .oe_n    (mem_oe_n),
    .ub_n    (upper_byte_select_n),
    .lb_n    (lower_byte_select_n),
    .addr    (mem_addr),
    .dq_o    (mem_dq_o),
    .dq_oe   (mem_dq_oe),
    .dq_i    (mem_dq_i)
  );

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
endmodule : ambwp_host

// ===== ambwp_regs.svh
// register map, field positions, reset values and timing counts for the
// block write-protect host controller
// assumes a 125 MHz pclk; included by the package users by bare name
`ifndef AMBWP_REGS_SVH
`define AMBWP_REGS_SVH

`define AMBWP_CTRL_OFS   8'h00
`define AMBWP_ADDR_OFS   8'h04
`define AMBWP_WDATA_OFS  8'h08
`define AMBWP_PROT_OFS   8'h0C
`define AMBWP_STAT_OFS   8'h10
`define AMBWP_RDATA_OFS  8'h14

`define AMBWP_CTRL_START 0
`define AMBWP_CTRL_WRITE 1
`define AMBWP_CTRL_PROT  2
`define AMBWP_STAT_BUSY  0
`define AMBWP_STAT_DONE  1
`define AMBWP_STAT_REFUS 2
`define AMBWP_BE_RST     2'h3
`define AMBWP_STEP_LAST  4'h9

`define AMBWP_SEQ_A0 17'h12555
`define AMBWP_SEQ_A1 17'h1DAAA
`define AMBWP_SEQ_A2 17'h01333
`define AMBWP_SEQ_A3 17'h0ECCC
`define AMBWP_SEQ_A4 17'h000FF
`define AMBWP_SEQ_A5 17'h1FF00
`define AMBWP_SEQ_A8 17'h0FF00
`define AMBWP_SEQ_A9 17'h00000

`define AMBWP_CLK_PS        8000
`define AMBWP_T_ADDR_SET_NS 10
`define AMBWP_T_ACCESS_NS   60
`define AMBWP_T_PRECH_NS    30
`define AMBWP_SETUP_CYC \
  ((`AMBWP_T_ADDR_SET_NS*1000+`AMBWP_CLK_PS-1)/`AMBWP_CLK_PS)
`define AMBWP_ACCESS_CYC \
  ((`AMBWP_T_ACCESS_NS*1000+`AMBWP_CLK_PS-1)/`AMBWP_CLK_PS)
`define AMBWP_PRECH_CYC \
  ((`AMBWP_T_PRECH_NS*1000+`AMBWP_CLK_PS-1)/`AMBWP_CLK_PS)

`endif

// ===== ambwp_pkg.sv
// types shared by the write-protect host controller modules
// assumes nothing beyond a SystemVerilog compiler
package ambwp_pkg;
  typedef enum logic [1:0] {
    CS_IDLE   = 2'b00,
    CS_SETUP  = 2'b01,
    CS_ACCESS = 2'b10,
    CS_PRECH  = 2'b11
  } ambwp_cyc_state_type;

  typedef enum logic [1:0] {
    SQ_IDLE  = 2'b00,
    SQ_ISSUE = 2'b01,
    SQ_WAIT  = 2'b10
  } ambwp_seq_state_type;
endpackage : ambwp_pkg

// ===== ambwp_mem_if.sv
// one memory access request and its answer between sequencer and pin engine
// assumes both ends run on pclk
`timescale 1ns/1ps
interface ambwp_mem_if;
  logic        req;
  logic        write;
  logic [16:0] addr;
  logic [15:0] wdata;
  logic [1:0]  be;
  logic        ack;
  logic [15:0] rdata;

  modport ctl (output req, write, addr, wdata, be, input ack, rdata);
  modport cyc (input req, write, addr, wdata, be, output ack, rdata);
endinterface : ambwp_mem_if

// ===== ambwp_cycle.sv
// pin engine: runs one chip-select-framed read or write on the memory pins
// assumes req only while idle; dq_i is synchronous to pclk
`timescale 1ns/1ps
`include "ambwp_regs.svh"
module ambwp_cycle
  import ambwp_pkg::*;
#(
  parameter int SETUP_CYC  = `AMBWP_SETUP_CYC,
  parameter int ACCESS_CYC = `AMBWP_ACCESS_CYC,
  parameter int PRECH_CYC  = `AMBWP_PRECH_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  ambwp_mem_if.cyc         mem,
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n,
  output logic             ub_n,
  output logic             lb_n,
  output logic [16:0]      addr,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  input  wire logic [15:0] dq_i
);
  ambwp_cyc_state_type state_q;
  logic [3:0]  cnt_q;
  logic        wr_q, ce_n_q, we_n_q, oe_n_q, ub_n_q, lb_n_q, dq_oe_q;
  logic [16:0] addr_q;
  logic [15:0] dq_o_q, rdata_q;
  logic        ack_q, zero;

  assign zero = (cnt_q == 4'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CS_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      case (state_q)
        CS_IDLE: if (mem.req) begin
          state_q <= CS_SETUP;
          cnt_q   <= 4'(SETUP_CYC - 1);
        end
        CS_SETUP: if (zero) begin
          state_q <= CS_ACCESS;
          cnt_q   <= 4'(ACCESS_CYC - 1);
        end else cnt_q <= cnt_q - 4'h1;
        CS_ACCESS: if (zero) begin
          state_q <= CS_PRECH;
          cnt_q   <= 4'(PRECH_CYC - 1);
        end else cnt_q <= cnt_q - 4'h1;
        CS_PRECH: if (zero) state_q <= CS_IDLE;
        else cnt_q <= cnt_q - 4'h1;
        default: state_q <= CS_IDLE;
      endcase
    end
  end

  // write strobe idles high from reset so a power cycle never sees it low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      ub_n_q  <= 1'b1;
      lb_n_q  <= 1'b1;
      dq_oe_q <= 1'b0;
      wr_q    <= 1'b0;
      addr_q  <= 17'h00000;
      dq_o_q  <= 16'h0000;
    end else begin
      if (state_q == CS_IDLE && mem.req) begin
        addr_q  <= mem.addr;
        dq_o_q  <= mem.wdata;
        wr_q    <= mem.write;
        dq_oe_q <= mem.write;
        ub_n_q  <= ~mem.be[1];
        lb_n_q  <= ~mem.be[0];
      end
      if (state_q == CS_SETUP && zero) begin
        ce_n_q <= 1'b0;
        we_n_q <= ~wr_q;
        oe_n_q <= wr_q;
      end
      if (state_q == CS_ACCESS && zero) begin
        ce_n_q <= 1'b1;
        we_n_q <= 1'b1;
        oe_n_q <= 1'b1;
      end
      // data and byte selects held through precharge for write hold time
      if (state_q == CS_PRECH && zero) begin
        dq_oe_q <= 1'b0;
        ub_n_q  <= 1'b1;
        lb_n_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= (state_q == CS_PRECH) && zero;
      if (state_q == CS_ACCESS && zero && !wr_q) rdata_q <= dq_i;
    end
  end

  assign mem.ack   = ack_q;
  assign mem.rdata = rdata_q;
  assign ce_n  = ce_n_q;
  assign we_n  = we_n_q;
  assign oe_n  = oe_n_q;
  assign ub_n  = ub_n_q;
  assign lb_n  = lb_n_q;
  assign addr  = addr_q;
  assign dq_o  = dq_o_q;
  assign dq_oe = dq_oe_q;
endmodule : ambwp_cycle

// ===== ambwp_host_monitor.sv
// concurrent checks on the memory pins and apb answer of the host controller
// assumes it is bound into ambwp_host and sees only that module's ports
`timescale 1ns/1ps
module ambwp_host_monitor #(
  parameter int SETUP_CYC  = 2,
  parameter int ACCESS_CYC = 8,
  parameter int PRECH_CYC  = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        mem_ce_n,
  input wire logic        mem_we_n,
  input wire logic        mem_oe_n,
  input wire logic        upper_byte_select_n,
  input wire logic        lower_byte_select_n,
  input wire logic [16:0] mem_addr,
  input wire logic [15:0] mem_dq_o,
  input wire logic        mem_dq_oe
);
  logic [7:0]  lo_q;
  logic [7:0]  hi_q;
  logic [16:0] wa_q;
  logic [7:0]  wd_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_q <= 8'h00;
    else lo_q <= mem_ce_n ? 8'h00 : lo_q + 8'h01;
  end
  // saturates so an idle bus never wraps into a short precharge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_q <= 8'h00;
    else if (!mem_ce_n) hi_q <= 8'h00;
    else if (hi_q != 8'hFF) hi_q <= hi_q + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wa_q <= 17'h00000;
      wd_q <= 8'h00;
    end else if (!mem_we_n) begin
      wa_q <= mem_addr;
      wd_q <= mem_dq_o[7:0];
    end
  end
  we_in_frame_a: assert property (!mem_we_n |-> !mem_ce_n)
    else $error("write strobe low outside chip select");
  addr_stable_a: assert property (
    !mem_ce_n && $past(!mem_ce_n) |-> $stable(mem_addr))
    else $error("address moved while selected");
  addr_setup_a: assert property (
    $fell(mem_ce_n) |-> $past(mem_addr, SETUP_CYC) == mem_addr)
    else $error("address not set up before chip select");
  access_len_a: assert property ($rose(mem_ce_n) |-> lo_q == ACCESS_CYC)
    else $error("chip select low for wrong length");
  prech_len_a: assert property (
    $fell(mem_ce_n) |-> hi_q >= PRECH_CYC + 3)
    else $error("precharge too short");
  bytesel_stable_a: assert property (
    !mem_ce_n && $past(!mem_ce_n) |->
    $stable({upper_byte_select_n, lower_byte_select_n}))
    else $error("byte selects moved while selected");
  write_drive_a: assert property (
    !mem_we_n |-> mem_dq_oe && mem_oe_n)
    else $error("write without data drive");
  compl_write_a: assert property (
    $fell(mem_we_n) && mem_addr == 17'h0ECCC && wa_q == 17'h1DAAA
    |-> mem_dq_o[7:0] == ~wd_q)
    else $error("confirm write is not the complement");
  one_wait_a: assert property (
    psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
endmodule : ambwp_host_monitor

// ===== ambwp_dev_model.sv
// behavioural model of the protected memory as seen from its pins
// assumes pins change only on pclk edges; array starts as its own address
`timescale 1ns/1ps
module ambwp_dev_model (
  input  wire logic        pclk,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        ub_n,
  input  wire logic        lb_n,
  input  wire logic [16:0] addr,
  input  wire logic [15:0] dq,
  output logic      [15:0] dq_i = 16'h0000
);
  logic [15:0] mem [logic [16:0]];
  logic [16:0] seq [6] = '{17'h12555, 17'h1DAAA, 17'h01333,
                           17'h0ECCC, 17'h000FF, 17'h1FF00};
  logic [7:0]  prot_q = 8'h00;
  logic [7:0]  pend_q;
  logic [16:0] la_q;
  logic [15:0] wd_q;
  logic [15:0] old;
  logic [15:0] cur;
  logic [1:0]  wbe_q;
  logic        wr_q = 1'b0;
  logic        on_q = 1'b0;
  int          step_q = 0;
  int          rows_q = 0;
  function automatic logic [15:0] rd(input logic [16:0] a);
    return mem.exists(a) ? mem[a] : a[15:0];
  endfunction : rd
  always @(posedge pclk) begin
    // access closes on deselect or address change, no ce toggle needed
    if (on_q && (ce_n || addr != la_q)) begin
      rows_q++;
      if (wr_q && step_q == 6) begin
        pend_q = wd_q[7:0];
        step_q = 7;
      end else if (wr_q && step_q == 7) begin
        if (wd_q[7:0] == ~pend_q) prot_q = pend_q;
        step_q = 0;
      end else if (wr_q) begin
        step_q = 0;
        old = rd(la_q);
        if (!prot_q[la_q[16:14]])
          mem[la_q] = {wbe_q[1] ? wd_q[15:8] : old[15:8],
                       wbe_q[0] ? wd_q[7:0] : old[7:0]};
      end else if (step_q < 6 && la_q == seq[step_q]) step_q++;
      else step_q = (la_q == seq[0]) ? 1 : 0;
      on_q = 1'b0;
    end
    if (!ce_n && !on_q) begin
      on_q = 1'b1;
      la_q = addr;
      wr_q = 1'b0;
    end
    if (!ce_n && !we_n) begin
      wr_q = 1'b1;
      wd_q = dq;
      wbe_q = {!ub_n, !lb_n};
    end
    // undriven lanes show the inverse of their last value; no page mode
    cur = rd(addr);
    dq_i <= {(!ce_n && !oe_n && !ub_n) ? cur[15:8] : ~dq_i[15:8],
             (!ce_n && !oe_n && !lb_n) ? cur[7:0] : ~dq_i[7:0]};
  end
endmodule : ambwp_dev_model

// ===== ambwp_host_test.sv
// self-checking bench: apb orders to the host, memory model on its pins
// assumes the default short timing parameters of the host
`timescale 1ns/1ps
`include "ambwp_regs.svh"
module ambwp_host_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        ce_n, we_n, oe_n, ub_n, lb_n, dq_oe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [16:0] maddr;
  logic [15:0] dq_o, dq_i;
  int          error_cnt = 0;
  int          checks = 0;
  logic [16:0] wa [5] = '{17'h0C010, 17'h0BFFF, 17'h0C000, 17'h13FFF,
                          17'h14000};
  logic [15:0] ex [5] = '{16'h12CD, 16'h5555, 16'hC000, 16'h3FFF, 16'h5555};
  ambwp_host ambwp_host_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_ce_n(ce_n),
    .mem_we_n(we_n), .mem_oe_n(oe_n), .upper_byte_select_n(ub_n),
    .lower_byte_select_n(lb_n), .mem_addr(maddr), .mem_dq_o(dq_o),
    .mem_dq_oe(dq_oe), .mem_dq_i(dq_i));
  ambwp_dev_model ambwp_dev_model_inst (.pclk, .ce_n, .we_n, .oe_n, .ub_n,
    .lb_n, .addr(maddr), .dq(dq_o), .dq_i);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // answer is taken at the very edge that samples pready high
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    err = pslverr;
    if (pready !== 1'b1) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_done();
    int n;
    for (n = 0; n < 100; n++) begin
      apb(1'b0, `AMBWP_STAT_OFS, 32'h0);
      if (r[`AMBWP_STAT_DONE] === 1'b1) break;
    end
    chk(n < 100, 32'h1);
    apb(1'b1, `AMBWP_STAT_OFS, 32'h6);
  endtask : wait_done
  task automatic op(input logic wr, input logic [16:0] a,
                    input logic [15:0] d, input logic [1:0] be);
    apb(1'b1, `AMBWP_ADDR_OFS, {15'h0, a});
    apb(1'b1, `AMBWP_WDATA_OFS, {14'h0, be, d});
    apb(1'b1, `AMBWP_CTRL_OFS, {30'h0, wr, 1'b1});
    wait_done();
    apb(1'b0, `AMBWP_RDATA_OFS, 32'h0);
  endtask : op
  task automatic rdchk(input logic [16:0] a, input logic [15:0] e);
    op(1'b0, a, 16'h0, 2'h3);
    chk(r, {16'h0, e});
  endtask : rdchk
  task automatic protect(input logic [7:0] b);
    apb(1'b1, `AMBWP_PROT_OFS, {24'h0, b});
    apb(1'b1, `AMBWP_CTRL_OFS, 32'h5);
    // an order while busy must be refused and flagged
    apb(1'b1, `AMBWP_ADDR_OFS, 32'h0);
    apb(1'b0, `AMBWP_STAT_OFS, 32'h0);
    chk(r[2:0], 32'h5);
    wait_done();
    apb(1'b0, `AMBWP_STAT_OFS, 32'h0);
    chk(r[15:0], {16'h0, b, 8'h00});
    chk(ambwp_dev_model_inst.prot_q, b);
  endtask : protect
  task automatic end_of_test();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    chk(we_n, 32'h1);
    chk(ce_n, 32'h1);
    chk(ambwp_dev_model_inst.prot_q, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, `AMBWP_STAT_OFS, 32'h0);
    chk(r, 32'h0);
    op(1'b1, 17'h0C010, 16'h1234, 2'h3);
    op(1'b1, 17'h0C010, 16'hABCD, 2'h1);
    rdchk(17'h0C010, 16'h12CD);
    op(1'b1, 17'h00010, 16'hABCD, 2'h2);
    rdchk(17'h00010, 16'hAB10);
    protect(8'h18);
    rdchk(17'h1DAAA, 16'hDAAA);
    rdchk(17'h0ECCC, 16'hECCC);
    foreach (wa[i]) begin
      op(1'b1, wa[i], 16'h5555, 2'h3);
      rdchk(wa[i], ex[i]);
    end
    protect(8'h00);
    op(1'b1, 17'h0C010, 16'h5555, 2'h3);
    rdchk(17'h0C010, 16'h5555);
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 32'h1);
    chk(r, 32'h0);
    end_of_test();
  end
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule : ambwp_host_test
bind ambwp_host ambwp_host_monitor #(.SETUP_CYC(SETUP_CYC),
  .ACCESS_CYC(ACCESS_CYC), .PRECH_CYC(PRECH_CYC)) ambwp_host_monitor_inst (
  .pclk, .presetn, .psel, .penable, .pready, .mem_ce_n, .mem_we_n, .mem_oe_n,
  .upper_byte_select_n, .lower_byte_select_n, .mem_addr, .mem_dq_o,
  .mem_dq_oe);
